// ===== verilog/pmr_params.svh
// Timing and field constants for the two-wire register link.
// Assumes a 125 MHz system clock on both ends.
`ifndef PMR_PARAMS_SVH
`define PMR_PARAMS_SVH
`define PMR_SLAVE_ADDR 7'h60
`define PMR_DIR_READ 1'b1
`define PMR_REG_COUNT 32
`define PMR_IDX_W 5
`define PMR_CLK_NS 8
`define PMR_SCL_NS 296
`define PMR_HALF_CYC ((`PMR_SCL_NS / 2) / `PMR_CLK_NS)
`define PMR_DIV_W 8
`endif

// ===== verilog/pmr_pkg.sv
// Shared types for the register link ends.
// Assumes pmr_params.svh for numeric constants.
package pmr_pkg;
	typedef enum logic [2:0] {
		PMR_S_IDLE = 3'h0,
		PMR_S_ADDR = 3'h1,
		PMR_S_INDEX = 3'h3,
		PMR_S_WDATA = 3'h2,
		PMR_S_RDATA = 3'h6,
		PMR_S_SKIP = 3'h7
	} pmr_slave_state_t;
	typedef enum logic [2:0] {
		PMR_M_IDLE = 3'h0,
		PMR_M_START = 3'h1,
		PMR_M_BIT = 3'h3,
		PMR_M_STOP = 3'h2,
		PMR_M_DONE = 3'h6
	} pmr_master_state_t;
endpackage : pmr_pkg

// ===== verilog/pmr_link_if.sv
// Two-wire link between the host master end and the device slave end.
// Resolves open-drain levels from the output enables; pull-ups assumed.
`timescale 1ns/1ps
interface pmr_link_if;
	logic scl_oe;
	logic sda_m_oe;
	logic sda_s_oe;
	logic scl;
	logic sda;
	assign scl = ~scl_oe;
	assign sda = ~(sda_m_oe | sda_s_oe);
	modport master (output scl_oe, output sda_m_oe, input scl, input sda);
	modport slave (output sda_s_oe, input scl, input sda);
endinterface : pmr_link_if

// ===== verilog/pmr_dev_slave.sv
// Device end: two-wire slave holding the byte-wide register set.
// Assumes the link pins are asynchronous; they pass two flip-flops first.
//
// Notes on behaviour
// - Oversampling supports all four bus rates
// - Driven SDA changes only while SCL low
// - SDA falling while SCL high is START
// - SDA rising while SCL high is STOP
// - Only the master makes START and STOP
// - Eight bits MSB first, then acknowledge
// - Master clocks acknowledge, releases SDA
// - Device acknowledges each received byte; here a data byte is nacked while the two-entry buffer is full
// - Master ends reads with negative acknowledge
// - Never drive SDA during undervoltage lockout
// - Address byte: seven bits plus direction
// - Write: index byte then data byte
// - Master sets index before reading
// - Respond to slave address 0x60
// - Index increments after each written byte
// - Reads do not advance the index
// - Access allowed in standby and active
// - Load defaults into registers in OTP state
// - All control via byte-wide registers
`timescale 1ns/1ps
`include "pmr_params.svh"
module pmr_dev_slave (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	pmr_link_if.slave link,
	input wire logic analog_supply_input_in,
	input wire logic otp_load_in,
	input wire logic [7:0] otp_data_in,
	input wire logic access_en_in,
	output logic [`PMR_IDX_W-1:0] otp_idx_out,
	output logic [7:0] wr_data_out,
	output logic [`PMR_IDX_W-1:0] wr_idx_out,
	output logic wr_valid_out,
	input wire logic wr_ready_in
);
	logic [7:0] regs_reg [0:`PMR_REG_COUNT-1];
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic [1:0] uv_sync_reg;
	logic scl_d_reg;
	logic sda_d_reg;
	pmr_pkg::pmr_slave_state_t state_reg;
	logic [3:0] bit_reg;
	logic [7:0] shift_reg;
	logic [`PMR_IDX_W-1:0] idx_reg;
	logic sda_oe_reg;
	logic ack_phase_reg;
	logic [`PMR_IDX_W-1:0] otp_idx_reg;
	logic [7:0] buf_data_reg [0:1];
	logic [`PMR_IDX_W-1:0] buf_idx_reg [0:1];
	logic [1:0] buf_cnt_reg;
	logic buf_wp_reg;
	logic buf_rp_reg;
	logic scl_s;
	logic sda_s;
	logic uv_s;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic push;
	logic pop;

	assign scl_s = scl_sync_reg[1];
	assign sda_s = sda_sync_reg[1];
	assign uv_s = uv_sync_reg[1];
	// Sampling at 125 MHz gives over 30 samples per bit even at 3.4 MHz
	assign scl_rise = scl_s & ~scl_d_reg;
	assign scl_fall = ~scl_s & scl_d_reg;
	assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_ev = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			uv_sync_reg <= 2'h3;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else if (ce_in) begin
			scl_sync_reg <= {scl_sync_reg[0], link.scl};
			sda_sync_reg <= {sda_sync_reg[0], link.sda};
			uv_sync_reg <= {uv_sync_reg[0], analog_supply_input_in};
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	// Protocol engine; the master alone makes START/STOP, the slave only reacts
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_reg <= pmr_pkg::PMR_S_IDLE;
			bit_reg <= 4'h0;
			shift_reg <= 8'h00;
			idx_reg <= '0;
			sda_oe_reg <= 1'b0;
			ack_phase_reg <= 1'b0;
		end else if (ce_in) begin
			if (stop_ev || uv_s) begin
				state_reg <= pmr_pkg::PMR_S_IDLE;
				sda_oe_reg <= 1'b0;
				ack_phase_reg <= 1'b0;
			end else if (start_ev) begin
				state_reg <= pmr_pkg::PMR_S_ADDR;
				bit_reg <= 4'h0;
				sda_oe_reg <= 1'b0;
				ack_phase_reg <= 1'b0;
			end else if (scl_rise && ack_phase_reg) begin
				// Host left SDA high after read data: send nothing more until STOP or a new START
				if (state_reg == pmr_pkg::PMR_S_RDATA && sda_s) begin
					state_reg <= pmr_pkg::PMR_S_SKIP;
				end
			end else if (scl_rise && !ack_phase_reg) begin
				shift_reg <= {shift_reg[6:0], sda_s};
				bit_reg <= bit_reg + 4'h1;
			end else if (scl_fall) begin
				if (ack_phase_reg) begin
					// Ack slot over: release, or present the next read bit
					ack_phase_reg <= 1'b0;
					bit_reg <= 4'h0;
					sda_oe_reg <= 1'b0;
					if (state_reg == pmr_pkg::PMR_S_RDATA) begin
						shift_reg <= regs_reg[idx_reg];
						sda_oe_reg <= ~regs_reg[idx_reg][7];
					end
				end else if (state_reg == pmr_pkg::PMR_S_RDATA && bit_reg != 4'h0) begin
					if (bit_reg == 4'h8) begin
						sda_oe_reg <= 1'b0;
						ack_phase_reg <= 1'b1;
					end else begin
						// Each rise has already moved the next bit to the top
						sda_oe_reg <= ~shift_reg[7];
					end
				end else if (bit_reg == 4'h8) begin
					ack_phase_reg <= 1'b1;
					case (state_reg)
						pmr_pkg::PMR_S_ADDR: begin
							if (shift_reg[7:1] == `PMR_SLAVE_ADDR && access_en_in) begin
								sda_oe_reg <= 1'b1;
								state_reg <= (shift_reg[0] == `PMR_DIR_READ) ?
									pmr_pkg::PMR_S_RDATA : pmr_pkg::PMR_S_INDEX;
							end else begin
								state_reg <= pmr_pkg::PMR_S_SKIP;
							end
						end
						pmr_pkg::PMR_S_INDEX: begin
							idx_reg <= shift_reg[`PMR_IDX_W-1:0];
							sda_oe_reg <= 1'b1;
							state_reg <= pmr_pkg::PMR_S_WDATA;
						end
						pmr_pkg::PMR_S_WDATA: begin
							// Nack when the buffer is full so no word is lost silently
							sda_oe_reg <= (buf_cnt_reg != 2'h2);
							if (buf_cnt_reg != 2'h2) begin
								idx_reg <= idx_reg + `PMR_IDX_W'(1);
							end
						end
						default: begin
							sda_oe_reg <= 1'b0;
						end
					endcase
				end
			end
		end
	end

	assign push = ce_in && scl_fall && !ack_phase_reg && bit_reg == 4'h8 &&
		state_reg == pmr_pkg::PMR_S_WDATA && buf_cnt_reg != 2'h2;
	assign pop = ce_in && wr_valid_out && wr_ready_in;

	// Two-entry buffer between the link and the register-side consumer
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			buf_cnt_reg <= 2'h0;
			buf_wp_reg <= 1'b0;
			buf_rp_reg <= 1'b0;
			buf_data_reg[0] <= 8'h00;
			buf_data_reg[1] <= 8'h00;
			buf_idx_reg[0] <= '0;
			buf_idx_reg[1] <= '0;
		end else begin
			if (push) begin
				buf_data_reg[buf_wp_reg] <= shift_reg;
				buf_idx_reg[buf_wp_reg] <= idx_reg;
				buf_wp_reg <= ~buf_wp_reg;
			end
			if (pop) begin
				buf_rp_reg <= ~buf_rp_reg;
			end
			buf_cnt_reg <= buf_cnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_valid_out <= 1'b0;
			wr_data_out <= 8'h00;
			wr_idx_out <= '0;
		end else if (ce_in) begin
			wr_valid_out <= (buf_cnt_reg - {1'b0, pop}) != 2'h0 || push;
			wr_data_out <= buf_data_reg[buf_rp_reg ^ pop];
			wr_idx_out <= buf_idx_reg[buf_rp_reg ^ pop];
			if (push && (buf_cnt_reg - {1'b0, pop}) == 2'h0) begin
				wr_data_out <= shift_reg;
				wr_idx_out <= idx_reg;
			end
		end
	end

	// Register file: defaults load in OTP state, writes drain from the buffer
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			otp_idx_reg <= '0;
			for (int i = 0; i < `PMR_REG_COUNT; i++) begin
				regs_reg[i] <= 8'h00;
			end
		end else if (ce_in) begin
			if (otp_load_in) begin
				regs_reg[otp_idx_reg] <= otp_data_in;
				otp_idx_reg <= otp_idx_reg + `PMR_IDX_W'(1);
			end else if (pop && access_en_in) begin
				regs_reg[wr_idx_out] <= wr_data_out;
			end
		end
	end

	assign otp_idx_out = otp_idx_reg;
	// Lockout gates the drive immediately, before the state machine reacts
	assign link.sda_s_oe = sda_oe_reg & ~uv_s;
endmodule : pmr_dev_slave

// ===== verilog/pmr_host_master.sv
// Host end: two-wire master issuing single register writes and reads.
// Assumes the bus pins are asynchronous; SCL is made here by a divider.
`timescale 1ns/1ps
`include "pmr_params.svh"
module pmr_host_master (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	pmr_link_if.master link,
	input wire logic req_valid_in,
	input wire logic req_read_in,
	input wire logic [7:0] req_index_in,
	input wire logic [7:0] req_data_in,
	output logic req_ready_out,
	output logic done_out,
	output logic nack_out,
	output logic [7:0] rd_data_out
);
	pmr_pkg::pmr_master_state_t state_reg;
	logic [1:0] sda_sync_reg;
	logic [`PMR_DIV_W-1:0] div_reg;
	logic [1:0] phase_reg;
	logic [5:0] bit_reg;
	logic [43:0] seq_reg;
	logic [43:0] rel_reg;
	logic [5:0] len_reg;
	logic scl_oe_reg;
	logic sda_oe_reg;
	logic tick;

	assign tick = (div_reg == `PMR_DIV_W'(`PMR_HALF_CYC / 2));
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sda_sync_reg <= 2'h3;
			div_reg <= '0;
		end else if (ce_in) begin
			sda_sync_reg <= {sda_sync_reg[0], link.sda};
			div_reg <= tick ? '0 : div_reg + `PMR_DIV_W'(1);
		end
	end

	// Write: addr+W, index, data. Read: addr+W, index, Sr, addr+R, data with nack.
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_reg <= pmr_pkg::PMR_M_IDLE;
			phase_reg <= 2'h0;
			bit_reg <= 6'h00;
			seq_reg <= '0;
			rel_reg <= '0;
			len_reg <= 6'h00;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			req_ready_out <= 1'b0;
			done_out <= 1'b0;
			nack_out <= 1'b0;
			rd_data_out <= 8'h00;
		end else if (ce_in) begin
			done_out <= 1'b0;
			req_ready_out <= (state_reg == pmr_pkg::PMR_M_IDLE);
			case (state_reg)
				pmr_pkg::PMR_M_IDLE: begin
					if (req_valid_in && req_ready_out) begin
						req_ready_out <= 1'b0;
						nack_out <= 1'b0;
						seq_reg <= {`PMR_SLAVE_ADDR, 1'b0, 1'b1, req_index_in, 1'b1,
							req_read_in ? {`PMR_SLAVE_ADDR, 1'b1, 1'b1} : {req_data_in, 1'b1},
							8'hff, 1'b1, 8'hff};
						// Frame sits at the top so bit 43 goes out first
						rel_reg <= {8'h00, 1'b1, 8'h00, 1'b1,
							req_read_in ? 9'h001 : 9'h001, 8'hff, 1'b1, 8'h00};
						len_reg <= req_read_in ? 6'd36 : 6'd27;
						bit_reg <= 6'h00;
						phase_reg <= 2'h0;
						state_reg <= pmr_pkg::PMR_M_START;
					end
				end
				pmr_pkg::PMR_M_START: begin
					if (tick) begin
						if (scl_oe_reg) begin
							// Repeated start: SCL rises with SDA released before SDA falls
							scl_oe_reg <= 1'b0;
						end else if (phase_reg == 2'h0) begin
							sda_oe_reg <= 1'b1;
							phase_reg <= 2'h1;
						end else begin
							scl_oe_reg <= 1'b1;
							phase_reg <= 2'h0;
							state_reg <= pmr_pkg::PMR_M_BIT;
						end
					end
				end
				pmr_pkg::PMR_M_BIT: begin
					if (tick) begin
						phase_reg <= phase_reg + 2'h1;
						case (phase_reg)
							2'h0: sda_oe_reg <= ~seq_reg[43] & ~rel_reg[43];
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: begin
								if (rel_reg[43] && bit_reg == 6'd26 && len_reg == 6'd36) begin
									sda_oe_reg <= 1'b0;
								end
								// Only the three ack slots count; high read data is no refusal
								if (rel_reg[43] && seq_reg[43] && sda_sync_reg[1] &&
									bit_reg < 6'd27) begin
									nack_out <= 1'b1;
								end
								if (len_reg == 6'd36 && bit_reg > 6'd26 && bit_reg < 6'd35) begin
									rd_data_out <= {rd_data_out[6:0], sda_sync_reg[1]};
								end
							end
							default: begin
								scl_oe_reg <= 1'b1;
								seq_reg <= {seq_reg[42:0], 1'b1};
								rel_reg <= {rel_reg[42:0], 1'b0};
								bit_reg <= bit_reg + 6'h1;
								// Repeated start before the read address byte
								if (len_reg == 6'd36 && bit_reg == 6'd17) begin
									state_reg <= pmr_pkg::PMR_M_START;
									sda_oe_reg <= 1'b0;
								end
								if (bit_reg + 6'h1 == len_reg) begin
									state_reg <= pmr_pkg::PMR_M_STOP;
								end
							end
						endcase
					end
				end
				pmr_pkg::PMR_M_STOP: begin
					if (tick) begin
						phase_reg <= phase_reg + 2'h1;
						case (phase_reg)
							2'h0: sda_oe_reg <= 1'b1;
							2'h1: scl_oe_reg <= 1'b0;
							default: begin
								sda_oe_reg <= 1'b0;
								state_reg <= pmr_pkg::PMR_M_DONE;
							end
						endcase
					end
				end
				pmr_pkg::PMR_M_DONE: begin
					done_out <= 1'b1;
					state_reg <= pmr_pkg::PMR_M_IDLE;
				end
				default: state_reg <= pmr_pkg::PMR_M_IDLE;
			endcase
		end
	end

	assign link.scl_oe = scl_oe_reg;
	assign link.sda_m_oe = sda_oe_reg;
endmodule : pmr_host_master

// ===== sim/pmr_link_properties.sv
// Concurrent checks on the two-wire link between the host and device ends.
// Assumes the bench hands it the resolved bus levels and every output enable.
`timescale 1ns/1ps
`include "pmr_params.svh"
module pmr_link_properties (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic analog_supply_input_in,
	input wire logic scl_oe,
	input wire logic sda_m_oe,
	input wire logic sda_s_oe,
	input wire logic scl,
	input wire logic sda
);
	logic scl_reg, sda_reg, rw_reg;
	logic [3:0] bit_reg;
	logic [1:0] byte_reg;
	logic [7:0] shift_reg;
	wire logic frame_edge = scl_reg && scl && (sda_reg != sda);
	// Bit count follows SCL rises, so a START or STOP restarts it at zero
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			rw_reg <= 1'b0;
			bit_reg <= 4'h0;
			byte_reg <= 2'h0;
			shift_reg <= 8'h00;
		end else begin
			scl_reg <= scl;
			sda_reg <= sda;
			if (frame_edge) begin
				bit_reg <= 4'h0;
				byte_reg <= 2'h0;
			end else if (scl && !scl_reg) begin
				bit_reg <= (bit_reg == 4'h9) ? 4'h1 : bit_reg + 4'h1;
				if (bit_reg != 4'h8) shift_reg <= {shift_reg[6:0], sda};
				if (bit_reg == 4'h9 && byte_reg != 2'h3) byte_reg <= byte_reg + 2'h1;
				if (bit_reg == 4'h8 && byte_reg == 2'h0) rw_reg <= shift_reg[0];
			end
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	sequence s_high;
		scl && scl_reg;
	endsequence
	sequence s_slot;
		s_high ##0 bit_reg == 4'h9;
	endsequence
	property p_slave_hold;
		s_high |-> $stable(sda_s_oe);
	endproperty
	a_slave_hold: assert property (p_slave_hold) else $error("slave moved SDA in SCL high");
	property p_master_frames;
		s_high ##0 $changed(sda) |-> $changed(sda_m_oe);
	endproperty
	a_master_frames: assert property (p_master_frames) else $error("frame edge not by host");
	property p_lockout;
		analog_supply_input_in [*4] |-> !sda_s_oe;
	endproperty
	a_lockout: assert property (p_lockout) else $error("slave drove SDA in lockout");
	property p_ack_slot;
		s_high ##0 sda_s_oe ##0 (byte_reg == 2'h0 || !rw_reg) |-> bit_reg == 4'h9;
	endproperty
	a_ack_slot: assert property (p_ack_slot) else $error("slave drove outside ack slot");
	property p_addr_match;
		s_slot ##0 byte_reg == 2'h0 ##0 sda_s_oe |-> shift_reg[7:1] == `PMR_SLAVE_ADDR;
	endproperty
	a_addr_match: assert property (p_addr_match) else $error("ack for foreign address");
	property p_master_slot;
		s_slot ##0 (byte_reg == 2'h0 || !rw_reg) |-> !sda_m_oe;
	endproperty
	a_master_slot: assert property (p_master_slot) else $error("host held SDA in ack slot");
	property p_read_nack;
		s_slot ##0 byte_reg == 2'h1 ##0 rw_reg |-> sda;
	endproperty
	a_read_nack: assert property (p_read_nack) else $error("read byte not nacked");
	property p_idle_release;
		s_high ##0 bit_reg == 4'h0 |-> !sda_s_oe;
	endproperty
	a_idle_release: assert property (p_idle_release) else $error("slave drove between frames");
endmodule : pmr_link_properties

// ===== sim/pmr_i2c_register_slave_test.sv
// Bench joining the host and device ends over the link interface.
// Assumes a 125 MHz clock; defaults are loaded before access opens.
`timescale 1ns/1ps
`include "pmr_params.svh"
module pmr_i2c_register_slave_test;
	logic clk_in, resetn_in, ce_in, supply_low, otp_load, access_en, wr_ready, stall;
	logic req_valid, req_read, done, nack, req_ready, wr_valid;
	logic [7:0] req_index, req_data, rd_data, otp_data, wr_data, ri, rv;
	logic [`PMR_IDX_W-1:0] otp_idx, wr_idx;
	logic [7:0] mem [32];
	logic [9:0] res_q [$];
	logic [12:0] wr_q [$];
	logic [9:0] exp_r;
	logic [12:0] exp_w;
	int failures, samples_checked, done_cnt;
	pmr_link_if link ();
	pmr_dev_slave u_pmr_dev_slave (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
		.link(link), .analog_supply_input_in(supply_low), .otp_load_in(otp_load),
		.otp_data_in(otp_data), .access_en_in(access_en), .otp_idx_out(otp_idx),
		.wr_data_out(wr_data), .wr_idx_out(wr_idx), .wr_valid_out(wr_valid),
		.wr_ready_in(wr_ready));
	pmr_host_master u_pmr_host_master (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
		.link(link), .req_valid_in(req_valid), .req_read_in(req_read), .req_index_in(req_index),
		.req_data_in(req_data), .req_ready_out(req_ready), .done_out(done), .nack_out(nack),
		.rd_data_out(rd_data));
	pmr_link_properties u_pmr_link_properties (.clk_in(clk_in), .resetn_in(resetn_in),
		.analog_supply_input_in(supply_low), .scl_oe(link.scl_oe), .sda_m_oe(link.sda_m_oe),
		.sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda));
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	// Held-low ready fills the buffer; otherwise the receiver stalls at random
	always @(negedge clk_in) begin
		wr_ready <= stall ? 1'b0 : 1'($urandom_range(1));
		otp_data <= {3'h0, otp_idx} ^ 8'h3c;
	end
	always @(posedge clk_in) begin
		if (done === 1'b1) begin
			exp_r = (res_q.size() > 0) ? res_q.pop_front() : 10'hx;
			check({7'h0, nack, exp_r[9] ? rd_data : 8'h0}, {7'h0, exp_r[8], exp_r[9] ? exp_r[7:0] : 8'h0});
			done_cnt++;
		end
		if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
			exp_w = (wr_q.size() > 0) ? wr_q.pop_front() : 13'hx;
			check({3'h0, wr_idx, wr_data}, {3'h0, exp_w});
		end
	end
	task automatic wait_fail(input int n);
		if (n >= 20000) begin
			failures++;
			$display("ERROR %0t: handshake timed out", $time);
			tally_and_finish();
		end
	endtask : wait_fail
	task automatic host_op(input logic rd, input logic [7:0] idx, input logic [7:0] dat,
		input logic exp_nack);
		int n;
		int start;
		n = 0;
		start = done_cnt;
		@(negedge clk_in);
		while (req_ready !== 1'b1 && n < 20000) begin
			@(negedge clk_in);
			n++;
		end
		wait_fail(n);
		req_valid <= 1'b1;
		req_read <= rd;
		req_index <= idx;
		req_data <= dat;
		res_q.push_back({rd && !exp_nack, exp_nack, mem[idx[4:0]]});
		if (!rd && !exp_nack) begin
			wr_q.push_back({idx[4:0], dat});
			mem[idx[4:0]] = dat;
		end
		@(negedge clk_in);
		req_valid <= 1'b0;
		n = 0;
		while (done_cnt == start && n < 20000) begin
			@(negedge clk_in);
			n++;
		end
		wait_fail(n);
	endtask : host_op
	initial begin
		{resetn_in, supply_low, otp_load, access_en, req_valid, req_read} = '0;
		{req_index, req_data} = '0;
		ce_in = 1'b1;
		stall = 1'b0;
		failures = 0;
		samples_checked = 0;
		done_cnt = 0;
		void'($urandom(19085));
		repeat (12) @(posedge clk_in);
		@(negedge clk_in);
		resetn_in = 1'b1;
		// Defaults land one byte a cycle while the host is still locked out
		otp_load = 1'b1;
		repeat (40) @(negedge clk_in);
		otp_load = 1'b0;
		for (int i = 0; i < 32; i++) mem[i] = 8'(i) ^ 8'h3c;
		access_en = 1'b1;
		host_op(1'b1, 8'h00, 8'h00, 1'b0);
		host_op(1'b1, 8'h1f, 8'h00, 1'b0);
		host_op(1'b1, 8'h25, 8'h00, 1'b0);
		$display("Test defaults done");
		repeat (5) begin
			ri = 8'($urandom_range(31));
			rv = 8'($urandom);
			host_op(1'b0, ri, rv, 1'b0);
			host_op(1'b1, ri, 8'h00, 1'b0);
		end
		$display("Test write and read back done");
		stall = 1'b1;
		host_op(1'b0, 8'h02, 8'ha1, 1'b0);
		host_op(1'b0, 8'h03, 8'hb2, 1'b0);
		host_op(1'b0, 8'h04, 8'hc3, 1'b1);
		stall = 1'b0;
		host_op(1'b1, 8'h04, 8'h00, 1'b0);
		$display("Test buffer full done");
		supply_low = 1'b1;
		repeat (8) @(negedge clk_in);
		host_op(1'b0, 8'h06, 8'h5a, 1'b1);
		host_op(1'b1, 8'h06, 8'h00, 1'b1);
		supply_low = 1'b0;
		access_en = 1'b0;
		repeat (8) @(negedge clk_in);
		host_op(1'b0, 8'h07, 8'h11, 1'b1);
		access_en = 1'b1;
		host_op(1'b1, 8'h07, 8'h00, 1'b0);
		$display("Test refusals done");
		repeat (50) @(negedge clk_in);
		check(16'(wr_q.size()), 16'h0000);
		check(16'(res_q.size()), 16'h0000);
		tally_and_finish();
	end
endmodule : pmr_i2c_register_slave_test
